// >>> hw/mmc_regs.svh
// constants for the module management control-timing block
// assumes a 125 MHz reference clock; included by bare name
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH

`define MMC_FLAG_W         8
`define MMC_FLAG_DNR_BIT   0
`define MMC_MASK_RESET     8'h00
`define MMC_FLAGS_RESET    8'h00
`define MMC_REF_MHZ        125
`define MMC_TOFF_PDOWN_MS  300
`define MMC_READY_CYCLES   (`MMC_TOFF_PDOWN_MS * 1000 * `MMC_REF_MHZ)
`define MMC_TIMER_W        26

`endif

// >>> hw/mmc_pkg.sv
// types shared by the module management control-timing block
// assumes mmc_regs.svh sits on the include path
`include "mmc_regs.svh"
package mmc_pkg;
	// power state, one-hot
	typedef enum logic [2:0] {
		MMC_ST_ACTIVE = 3'h1,
		MMC_ST_LOWPWR = 3'h2,
		MMC_ST_WAKE   = 3'h4
	} mmc_state_t;
	typedef logic [`MMC_FLAG_W-1:0] mmc_flags_t;
endpackage

// >>> hw/mmc_link_side.sv
// link-side capture of two-wire writes and flag reads
// assumes linkClk rises on the serial clock's falling edge and that
// a protocol front end on the same clock gives the strobes below
`timescale 1ns/1ns
`include "mmc_regs.svh"
module mmc_link_side
	import mmc_pkg::*;
(
	input  wire logic       linkClk,
	input  wire logic       rst_n,
	input  wire logic       wrValid,
	input  wire mmc_flags_t wrMask,
	input  wire logic       wrPowerDown,
	input  wire logic       rdFlags,
	input  wire logic       stopFall,
	input  wire logic       ackTgl,
	output logic            reqTgl,
	output mmc_flags_t      shMask,
	output logic            shPowerDown,
	output logic            shWrite,
	output logic            shRead
);
	logic       ackMeta_reg, ackSync_reg;   // ack crossing
	logic       req_reg,     req_next;      // request toggle
	logic       pWr_reg,     pWr_next;      // write waiting for stop
	logic       pRd_reg,     pRd_next;      // read waiting for stop
	mmc_flags_t pMask_reg,   pMask_next;    // pending mask value
	logic       pPd_reg,     pPd_next;      // pending power-down value
	mmc_flags_t sMask_reg,   sMask_next;    // shadow held while in flight
	logic       sPd_reg,     sPd_next;
	logic       sWr_reg,     sWr_next;
	logic       sRd_reg,     sRd_next;
	logic       busy;

	assign busy        = req_reg != ackSync_reg;
	assign reqTgl      = req_reg;
	assign shMask      = sMask_reg;
	assign shPowerDown = sPd_reg;
	assign shWrite     = sWr_reg;
	assign shRead      = sRd_reg;

	// collect accesses, hand them over at the edge after the stop
	always_comb begin
		req_next   = req_reg;
		pWr_next   = pWr_reg | wrValid;
		pRd_next   = pRd_reg | rdFlags;
		pMask_next = wrValid ? wrMask : pMask_reg;
		pPd_next   = wrValid ? wrPowerDown : pPd_reg;
		sMask_next = sMask_reg;
		sPd_next   = sPd_reg;
		sWr_next   = sWr_reg;
		sRd_next   = sRd_reg;
		// a busy handshake keeps the access pending rather than losing it
		if (stopFall && !busy && (pWr_reg || pRd_reg)) begin // [R8]
			req_next   = ~req_reg;
			sMask_next = pMask_reg;
			sPd_next   = pPd_reg;
			sWr_next   = pWr_reg;
			sRd_next   = pRd_reg;
			pWr_next   = wrValid;
			pRd_next   = rdFlags;
		end
	end

	// registers only
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			ackMeta_reg <= 1'b0;
			ackSync_reg <= 1'b0;
			req_reg     <= 1'b0;
			pWr_reg     <= 1'b0;
			pRd_reg     <= 1'b0;
			pMask_reg   <= `MMC_MASK_RESET;
			pPd_reg     <= 1'b0;
			sMask_reg   <= `MMC_MASK_RESET;
			sPd_reg     <= 1'b0;
			sWr_reg     <= 1'b0;
			sRd_reg     <= 1'b0;
		end else begin
			ackMeta_reg <= ackTgl;
			ackSync_reg <= ackMeta_reg;
			req_reg     <= req_next;
			pWr_reg     <= pWr_next;
			pRd_reg     <= pRd_next;
			pMask_reg   <= pMask_next;
			pPd_reg     <= pPd_next;
			sMask_reg   <= sMask_next;
			sPd_reg     <= sPd_next;
			sWr_reg     <= sWr_next;
			sRd_reg     <= sRd_next;
		end
	end
endmodule

// >>> hw/mmc_ctrl.sv
// module management control timing: masking, select gating, power-down
// assumes pins arrive asynchronously and the link strobes on linkClk
//
// Behaviour
// [R1] setting a mask bit inhibits interrupt within 100 ms
// [R2] clearing a mask bit resumes interrupt within 100 ms
// [R3] select low enables bus answers within 100 us
// [R4] select high stops bus answers within 100 us
// [R5] power-down bit set enters low power within 100 ms
// [R6] power-down bit cleared: fully functional within 300 ms
// [R7] functional means not-ready cleared and interrupt raised
// [R8] write delays count from edge after stop
// [R9] read clears flags, interrupt released within 500 us
// [R10] condition sets flag and interrupt within 200 ms
// [R11] host holds reset pin low over 2 us
// [R12] interrupt low while any unmasked flag set
`timescale 1ns/1ns
`include "mmc_regs.svh"
module mmc_ctrl
	import mmc_pkg::*;
#(
	parameter int READY_CYCLES = `MMC_READY_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       linkClk,
	input  wire logic       module_select_n,
	input  wire logic       module_reset_n,
	input  wire logic       low_power_pin,
	input  wire mmc_flags_t flagCond,
	input  wire logic       wrValid,
	input  wire mmc_flags_t wrMask,
	input  wire logic       wrPowerDown,
	input  wire logic       rdFlags,
	input  wire logic       stopFall,
	output logic            interrupt_out_n,
	output logic            presence_out_n,
	output logic            respondEnable,
	output logic            lowPowerState,
	output logic            dataNotReady,
	output mmc_flags_t      flagStatus,
	output mmc_flags_t      maskStatus
);
	// link side wires
	logic       reqTgl;      // request toggle from link domain
	mmc_flags_t shMask;      // held stable while request in flight
	logic       shPowerDown;
	logic       shWrite;
	logic       shRead;

	// pin synchronisers, first stage read only by second
	logic [2:0] pinMeta_reg;
	logic [2:0] pinSync_reg;
	logic [2:0] reqSync_reg; // meta, sync, previous
	logic       selSync, rstPinSync, lpSync, reqEvent;

	// state registers and next values
	logic                   ack_reg,     ack_next;
	mmc_flags_t             mask_reg,    mask_next;
	mmc_flags_t             flags_reg,   flags_next;
	logic                   pdBit_reg,   pdBit_next;
	logic                   resp_reg,    resp_next;
	logic                   lowPwr_reg,  lowPwr_next;
	logic                   dnr_reg,     dnr_next;
	logic                   intN_reg,    intN_next;
	logic [`MMC_TIMER_W-1:0] timer_reg,  timer_next;
	mmc_state_t             state_reg,   state_next;

	// handover from the link clock domain
	// the link side freezes its shadow copy while the request toggle
	// is in flight; this side samples that copy only after the toggle
	// has passed two flops, so the multi-bit word never crosses while
	// it is changing.  the acknowledge toggle goes back the same way.
	// trade-off: each access costs a few cycles in both domains, far
	// below every limit the control timing has to meet.
	mmc_link_side linkSide (
		.linkClk     (linkClk),
		.rst_n       (rst_n),
		.wrValid     (wrValid),
		.wrMask      (wrMask),
		.wrPowerDown (wrPowerDown),
		.rdFlags     (rdFlags),
		.stopFall    (stopFall),
		.ackTgl      (ack_reg),
		.reqTgl      (reqTgl),
		.shMask      (shMask),
		.shPowerDown (shPowerDown),
		.shWrite     (shWrite),
		.shRead      (shRead)
	);

	assign selSync    = pinSync_reg[0];
	assign rstPinSync = pinSync_reg[1];
	assign lpSync     = pinSync_reg[2];
	assign reqEvent   = reqSync_reg[1] != reqSync_reg[2];

	// presence flop, declared ahead of its first use
	logic presPin_reg;

	assign interrupt_out_n = intN_reg;
	assign presence_out_n  = presPin_reg;
	assign respondEnable   = resp_reg;
	assign lowPowerState   = lowPwr_reg;
	assign dataNotReady    = dnr_reg;
	assign flagStatus      = flags_reg;
	assign maskStatus      = mask_reg;

	// presence is high during reset and held low after it
	// kept as a flop so the pin never glitches while reset lets go
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			presPin_reg <= 1'b1;
		end else begin
			presPin_reg <= 1'b0;
		end
	end

	// next values for control, flags and power state
	always_comb begin
		ack_next   = ack_reg;
		mask_next  = mask_reg;
		pdBit_next = pdBit_reg;
		timer_next = timer_reg;
		state_next = state_reg;
		dnr_next   = dnr_reg;
		// new conditions set flags; a read clears the rest
		flags_next = flags_reg;
		if (reqEvent) begin
			ack_next = reqSync_reg[1];  // acknowledge once data used
			if (shWrite) begin
				mask_next  = shMask;      // [R1] [R2] [R8]
				pdBit_next = shPowerDown; // [R5] [R6] [R8]
			end
			if (shRead) begin
				flags_next = `MMC_FLAGS_RESET; // [R9]
			end
		end
		// set after clear so an event in the clearing cycle survives
		flags_next = flags_next | flagCond; // [R10]
		// power state machine
		// the power-down bit and the low power pin are ORed: either
		// one keeps the module in low power, and only with both clear
		// does the wake timer start.  leaving wake early on a new
		// request is allowed, since the timer restarts on the next
		// wake and so never reports ready too soon.
		unique case (state_reg)
			MMC_ST_ACTIVE: begin
				if (pdBit_next || lpSync) begin
					state_next = MMC_ST_LOWPWR; // [R5]
				end
			end
			MMC_ST_LOWPWR: begin
				if (!pdBit_next && !lpSync) begin
					state_next = MMC_ST_WAKE;
					dnr_next   = 1'b1;
					timer_next = '0;
				end
			end
			MMC_ST_WAKE: begin
				if (pdBit_next || lpSync) begin
					state_next = MMC_ST_LOWPWR;
				end else if (timer_reg ==
				    `MMC_TIMER_W'(READY_CYCLES - 1)) begin
					// ready: drop not-ready and raise its flag
					state_next = MMC_ST_ACTIVE; // [R6]
					dnr_next   = 1'b0;          // [R7]
					flags_next[`MMC_FLAG_DNR_BIT] = 1'b1; // [R7]
				end else begin
					timer_next = timer_reg + 1'b1;
				end
			end
		endcase
		// module reset pin restarts the device as after power on
		if (!rstPinSync) begin
			mask_next  = `MMC_MASK_RESET;
			pdBit_next = 1'b0;
			flags_next = `MMC_FLAGS_RESET;
			dnr_next   = 1'b1;
			timer_next = '0;
			state_next = MMC_ST_WAKE;
		end
		// outputs follow within a cycle or two, well inside limits
		// select answers are gated while the reset pin is low so that
		// a module held in reset never claims the serial bus
		resp_next   = !selSync && rstPinSync;        // [R3] [R4]
		lowPwr_next = state_next == MMC_ST_LOWPWR;   // [R5]
		intN_next   = ~|(flags_next & ~mask_next);   // [R12] [R1] [R2]
	end

	// registers only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_reg <= 3'h3;
			pinSync_reg <= 3'h3;
			reqSync_reg <= 3'h0;
			ack_reg     <= 1'b0;
			mask_reg    <= `MMC_MASK_RESET;
			flags_reg   <= `MMC_FLAGS_RESET;
			pdBit_reg   <= 1'b0;
			resp_reg    <= 1'b0;
			lowPwr_reg  <= 1'b0;
			dnr_reg     <= 1'b1;
			intN_reg    <= 1'b1;
			timer_reg   <= '0;
			state_reg   <= MMC_ST_WAKE;
		end else begin
			pinMeta_reg <= {low_power_pin, module_reset_n, module_select_n};
			pinSync_reg <= pinMeta_reg;
			reqSync_reg <= {reqSync_reg[1], reqSync_reg[0], reqTgl};
			ack_reg     <= ack_next;
			mask_reg    <= mask_next;
			flags_reg   <= flags_next;
			pdBit_reg   <= pdBit_next;
			resp_reg    <= resp_next;
			lowPwr_reg  <= lowPwr_next;
			dnr_reg     <= dnr_next;
			intN_reg    <= intN_next;
			timer_reg   <= timer_next;
			state_reg   <= state_next;
		end
	end
endmodule

// >>> dv/mmc_ctrl_asserts.sv
// checker on the control-timing block ports, ref_clk domain only
// assumes a bind onto mmc_ctrl; pins pass two sync flops first
`timescale 1ns/1ns
module mmc_ctrl_asserts
	import mmc_pkg::*;
#(parameter int READY_CYCLES = 20)
(
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       module_select_n,
	input wire logic       module_reset_n,
	input wire logic       low_power_pin,
	input wire mmc_flags_t flagCond,
	input wire logic       interrupt_out_n,
	input wire logic       respondEnable,
	input wire logic       lowPowerState,
	input wire logic       dataNotReady,
	input wire mmc_flags_t flagStatus,
	input wire mmc_flags_t maskStatus
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// pins held past the sync latency before any figure is due
	sequence s_sel; (!module_select_n && module_reset_n) [*5]; endsequence
	sequence s_pin; !module_reset_n [*5]; endsequence
	property p_int;
		interrupt_out_n == !(|(flagStatus & ~maskStatus));
	endproperty
	a_int: assert property (p_int) else $error("irq vs flags");
	property p_sel_on; s_sel |-> respondEnable; endproperty
	a_sel_on: assert property (p_sel_on) else $error("no answer");
	property p_sel_off; module_select_n [*5] |-> !respondEnable; endproperty
	a_sel_off: assert property (p_sel_off) else $error("answers");
	property p_lp; low_power_pin [*5] |-> lowPowerState; endproperty
	a_lp: assert property (p_lp) else $error("no low power");
	property p_rdy; $fell(dataNotReady) |-> ##[0:1] flagStatus[0]; endproperty
	a_rdy: assert property (p_rdy) else $error("ready flag");
	property p_rdy_int;
		$fell(dataNotReady) && !maskStatus[0] |-> ##[0:2] !interrupt_out_n;
	endproperty
	a_rdy_int: assert property (p_rdy_int) else $error("ready irq");
	property p_set;
		|flagCond |=> (flagStatus & $past(flagCond)) == $past(flagCond);
	endproperty
	a_set: assert property (p_set) else $error("flag not set");
	property p_pin;
		s_pin |-> maskStatus == 8'h00 && dataNotReady && !respondEnable;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset");
endmodule
bind mmc_ctrl mmc_ctrl_asserts #(.READY_CYCLES(READY_CYCLES)) chk_u (
	.ref_clk(ref_clk), .rst_n(rst_n), .module_select_n(module_select_n),
	.module_reset_n(module_reset_n), .low_power_pin(low_power_pin),
	.flagCond(flagCond), .interrupt_out_n(interrupt_out_n),
	.respondEnable(respondEnable), .lowPowerState(lowPowerState),
	.dataNotReady(dataNotReady), .flagStatus(flagStatus),
	.maskStatus(maskStatus));

// >>> dv/mmc_host_model.sv
// host side of the link: write and read frames with their stop edge
// assumes the bench calls acc(); the link clock idles low off frames
`timescale 1ns/1ns
module mmc_host_model
	import mmc_pkg::*;
(
	output logic       linkClk,
	output logic       wrValid,
	output mmc_flags_t wrMask,
	output logic       wrPowerDown,
	output logic       rdFlags,
	output logic       stopFall
);
	initial {linkClk, wrValid, wrMask, wrPowerDown, rdFlags, stopFall} = '0;
	// 15 ns link periods; strobes move just after the falling edge
	task automatic pulse(input int n);
		repeat (n) begin
			#7 linkClk = 1'b1;
			#7 linkClk = 1'b0;
			#1;
		end
	endtask
	// one access; trailing edges let the handover acknowledge
	task automatic acc(input logic w, input mmc_flags_t m, input logic pd);
		wrValid = w;
		rdFlags = !w;
		wrMask = m;
		wrPowerDown = pd;
		pulse(1);
		{wrValid, rdFlags} = 2'h0;
		wrMask = ~m; // released data never keeps its last value
		wrPowerDown = ~pd;
		stopFall = 1'b1;
		pulse(1);
		stopFall = 1'b0;
		pulse(6);
	endtask
endmodule

// >>> dv/mmc_ctrl_tb.sv
// self-checking bench for the control-timing block
// assumes the host model drives the link; ready delay cut to 20
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
	err_count++; $display("wrong value %s exp %h got %h", n, e, a); end end
module mmc_ctrl_tb;
	import mmc_pkg::*;
	logic       ref_clk, rst_n, module_select_n, module_reset_n;
	logic       low_power_pin, linkClk, wrValid, wrPowerDown, rdFlags;
	logic       stopFall, interrupt_out_n, respondEnable, lowPowerState;
	logic       dataNotReady, presence_out_n;
	mmc_flags_t flagCond, wrMask, flagStatus, maskStatus;
	int         err_count = 0;
	int         samples_checked = 0;
	mmc_host_model host_u (.linkClk(linkClk), .wrValid(wrValid),
		.wrMask(wrMask), .wrPowerDown(wrPowerDown), .rdFlags(rdFlags),
		.stopFall(stopFall));
	mmc_ctrl #(.READY_CYCLES(20)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.linkClk(linkClk), .module_select_n(module_select_n),
		.module_reset_n(module_reset_n), .low_power_pin(low_power_pin),
		.flagCond(flagCond), .wrValid(wrValid), .wrMask(wrMask),
		.wrPowerDown(wrPowerDown), .rdFlags(rdFlags), .stopFall(stopFall),
		.interrupt_out_n(interrupt_out_n), .presence_out_n(presence_out_n),
		.respondEnable(respondEnable), .lowPowerState(lowPowerState),
		.dataNotReady(dataNotReady), .flagStatus(flagStatus),
		.maskStatus(maskStatus));
	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;
	// inputs move 1 ns after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// bounded wait: 40 cycles covers sync plus the ready delay
	task automatic wait_ready();
		for (int i = 0; i < 40 && dataNotReady !== 1'b0; i++)
			cyc(1);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		{rst_n, low_power_pin, flagCond} = '0;
		{module_select_n, module_reset_n} = 2'h3;
		fork host_u.pulse(2); join_none
		cyc(3);
		`CHK("pres rst", 1'b1, presence_out_n)
		rst_n = 1'b1;
		cyc(1);
		`CHK("presence", 1'b0, presence_out_n)
		`CHK("wake", 1'b1, dataNotReady)
		wait_ready();
		`CHK("rdy flags", 8'h01, flagStatus)
		`CHK("rdy irq", 1'b0, interrupt_out_n)
		host_u.acc(1'b1, 8'h01, 1'b0);
		cyc(2);
		`CHK("mask", 8'h01, maskStatus)
		`CHK("masked irq", 1'b1, interrupt_out_n)
		host_u.acc(1'b1, 8'h00, 1'b0);
		cyc(2);
		`CHK("unmasked irq", 1'b0, interrupt_out_n)
		host_u.acc(1'b0, 8'h00, 1'b0);
		cyc(2);
		`CHK("read flags", 8'h00, flagStatus)
		`CHK("read irq", 1'b1, interrupt_out_n)
		flagCond = 8'h80;
		cyc(1);
		flagCond = 8'h00;
		cyc(2);
		`CHK("cond flags", 8'h80, flagStatus)
		`CHK("cond irq", 1'b0, interrupt_out_n)
		// mask and power-down in one write
		host_u.acc(1'b1, 8'h80, 1'b1);
		cyc(2);
		`CHK("pd irq", 1'b1, interrupt_out_n)
		`CHK("pd", 1'b1, lowPowerState)
		host_u.acc(1'b1, 8'h80, 1'b0);
		cyc(2);
		`CHK("pd off", 1'b1, dataNotReady)
		wait_ready();
		`CHK("up flags", 8'h81, flagStatus)
		`CHK("up irq", 1'b0, interrupt_out_n)
		low_power_pin = 1'b1;
		cyc(5);
		`CHK("lp pin", 1'b1, lowPowerState)
		low_power_pin = 1'b0;
		module_select_n = 1'b0;
		cyc(5);
		`CHK("sel on", 1'b1, respondEnable)
		module_reset_n = 1'b0;
		cyc(260); // beyond the minimum reset pulse
		`CHK("pin mask", 8'h00, maskStatus)
		`CHK("pin flags", 8'h00, flagStatus)
		`CHK("pin sel", 1'b0, respondEnable)
		module_reset_n = 1'b1;
		wait_ready();
		`CHK("restart", 1'b0, dataNotReady)
		`CHK("restart sel", 1'b1, respondEnable)
		module_select_n = 1'b1;
		cyc(6);
		`CHK("sel off", 1'b0, respondEnable)
		finish_test();
	end
	// watchdog: the sequence needs about 430 cycles
	initial begin
		#20000;
		err_count++;
		finish_test();
	end
endmodule
